// ===== hdl/gfsm_defines.svh
/*
 Constants for the pin function select multiplexer: register indices,
 field positions, select codes, reset values and bus answers.
 Assumes byte address = 4 * register index on a 32-bit register bus.
*/
`ifndef GFSM_DEFINES_SVH
`define GFSM_DEFINES_SVH

`define GFSM_IDX_PB_MODE_2     8'h56
`define GFSM_IDX_PB_MODE_10    8'h57
`define GFSM_IDX_PC_MODE_76    8'h58
`define GFSM_IDX_PC_MODE_54    8'h59
`define GFSM_IDX_PB_DATA       8'h60
`define GFSM_IDX_PC_DATA       8'h61
`define GFSM_IDX_INT_STAT      8'h62
`define GFSM_IDX_INT_MASK      8'h63

`define GFSM_HI_ROUTE          7
`define GFSM_HI_SEL            6:4
`define GFSM_LO_ROUTE          3
`define GFSM_LO_SEL            2:0

`define GFSM_WMASK_PB_MODE_2   8'h0f
`define GFSM_WMASK_RSV3        8'hf7
`define GFSM_WMASK_FULL        8'hff

`define GFSM_SEL_GP_IN         3'h0
`define GFSM_SEL_IRQ           3'h1
`define GFSM_SEL_ALT_IN        3'h2
`define GFSM_SEL_KEY_RET       3'h3
`define GFSM_SEL_GP_OUT        3'h4
`define GFSM_SEL_ALT_OUT       3'h5
`define GFSM_SEL_ALT_OUT2      3'h6
`define GFSM_SEL_KEY_DRV       3'h7

`define GFSM_MODE_RST          8'h00
`define GFSM_DATA_RST          8'h00
`define GFSM_MASK_RST          7'h00

`define GFSM_RESP_OKAY         2'h0
`define GFSM_RESP_SLVERR       2'h2

`endif

// ===== hdl/gfsm_pkg.sv
/*
 Types for the pin function select multiplexer.
 Assumes gfsm_defines.svh supplies the numeric constants.
*/
package gfsm_pkg;
    // pin order used by every vector of width 7
    typedef enum logic [2:0] {
        GFSM_PIN_B0, GFSM_PIN_B1, GFSM_PIN_B2,
        GFSM_PIN_C4, GFSM_PIN_C5, GFSM_PIN_C6, GFSM_PIN_C7
    } gfsm_pin_t;

    typedef struct packed {
        logic       oe;
        logic       o;
    } gfsm_drive_t;

    // functions the chip core offers to the pins
    typedef struct packed {
        logic       serial_transmit;
        logic [2:0] chip_sel;
        logic       sysclk;
        logic       bhe;
        logic       card_mem_rd;
        logic       card_mem_wr;
        logic       card_addr22;
        logic       card_addr21;
        logic [6:0] keyscan_drive;
    } gfsm_core_out_t;

    // pin levels delivered to the chip core
    typedef struct packed {
        logic [15:0] irq_req;
        logic        aux_status_input;
        logic        iocs16;
        logic        memcs16;
        logic        serial_receive;
        logic [6:0]  keyscan_return;
    } gfsm_core_in_t;
endpackage

// ===== hdl/gfsm_mux.sv
/*
 Pin function select multiplexer for port B pins 0..2 and port C pins 4..7,
 with mode, data, interrupt status and mask registers on AXI4-Lite.
 Assumes pin inputs are synchronous to aclk and one clock domain.
*/
`timescale 1ns/10ps
`include "gfsm_defines.svh"
module gfsm_mux #(
    parameter int ADDR_W = 12
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [ADDR_W-1:0]      s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [ADDR_W-1:0]      s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic [6:0]             pin_in,
    output logic [6:0]                  pin_out,
    output logic [6:0]                  pin_oe,
    input  wire gfsm_pkg::gfsm_core_out_t core_out,
    output gfsm_pkg::gfsm_core_in_t     core_in,
    output logic                        irq
);
    import gfsm_pkg::*;

    logic [7:0]          mode_pb2_reg;
    logic [7:0]          mode_pb10_reg;
    logic [7:0]          mode_pc76_reg;
    logic [7:0]          mode_pc54_reg;
    logic [7:0]          data_b_reg;
    logic [7:0]          data_c_reg;
    logic [6:0]          int_stat_reg;
    logic [6:0]          int_mask_reg;
    logic [6:0]          pin_in_q_reg;
    logic [2:0]          sel      [7];
    logic [6:0]          route;
    logic [6:0]          gp_data;
    logic [6:0]          irq_mode;
    logic [6:0]          irq_event;
    gfsm_drive_t         drv      [7];
    gfsm_core_in_t       core_in_next;
    logic                aw_full_reg;
    logic                w_full_reg;
    logic [ADDR_W-1:0]   awaddr_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;
    logic                wr_fire;
    logic                wr_done;
    logic [7:0]          wr_idx;
    logic                wr_byte;
    logic [7:0]          wr_val;
    logic [7:0]          rd_val;
    logic                rd_ok;

    // index from byte address; upper address bits must be zero to hit
    function automatic logic [8:0] addr_index(input logic [ADDR_W-1:0] a);
        logic ok;
        ok = (a >> 10) == '0;
        return {ok, a[9:2]};
    endfunction

    function automatic logic is_mapped(input logic [7:0] idx);
        return idx inside {`GFSM_IDX_PB_MODE_2, `GFSM_IDX_PB_MODE_10,
                           `GFSM_IDX_PC_MODE_76, `GFSM_IDX_PC_MODE_54,
                           `GFSM_IDX_PB_DATA, `GFSM_IDX_PC_DATA,
                           `GFSM_IDX_INT_STAT, `GFSM_IDX_INT_MASK};
    endfunction

    // pin 0 has no interrupt choice; every other pin here has one at 001
    function automatic logic is_irq(input logic [2:0] pin,
                                    input logic [2:0] s);
        return (s == `GFSM_SEL_IRQ) && (pin != 3'(GFSM_PIN_B0));
    endfunction

    // output drive per pin and select code
    function automatic gfsm_drive_t pin_drive(input logic [2:0]  pin,
                                              input logic [2:0]  s,
                                              input logic        gp,
                                              input gfsm_core_out_t c);
        gfsm_drive_t d;
        d = '{oe: 1'b0, o: 1'b0};
        case (s)
            `GFSM_SEL_GP_OUT: d = '{oe: 1'b1, o: gp};
            `GFSM_SEL_KEY_DRV: d = '{oe: 1'b1, o: c.keyscan_drive[pin]};
            `GFSM_SEL_ALT_OUT: begin
                case (pin)
                    3'(GFSM_PIN_B0): d = '{oe: 1'b1, o: c.serial_transmit};
                    3'(GFSM_PIN_B1): d = '{oe: 1'b1, o: gp};
                    3'(GFSM_PIN_B2): d = '{oe: 1'b1, o: c.serial_transmit};
                    3'(GFSM_PIN_C5): d = '{oe: 1'b1, o: c.serial_transmit};
                    3'(GFSM_PIN_C6): d = '{oe: 1'b1, o: c.bhe};
                    3'(GFSM_PIN_C7): d = '{oe: 1'b1, o: c.sysclk};
                    default: d = '{oe: 1'b0, o: 1'b0};
                endcase
            end
            `GFSM_SEL_ALT_OUT2: begin
                case (pin)
                    3'(GFSM_PIN_B0): d = '{oe: 1'b1, o: c.chip_sel[1]};
                    3'(GFSM_PIN_B1): d = '{oe: 1'b1, o: c.chip_sel[2]};
                    3'(GFSM_PIN_B2): d = '{oe: 1'b1, o: c.chip_sel[0]};
                    3'(GFSM_PIN_C4): d = '{oe: 1'b1, o: c.card_addr21};
                    3'(GFSM_PIN_C5): d = '{oe: 1'b1, o: c.card_addr22};
                    3'(GFSM_PIN_C6): d = '{oe: 1'b1, o: c.card_mem_wr};
                    3'(GFSM_PIN_C7): d = '{oe: 1'b1, o: c.card_mem_rd};
                    default: d = '{oe: 1'b0, o: 1'b0};
                endcase
            end
            default: d = '{oe: 1'b0, o: 1'b0};
        endcase
        return d;
    endfunction

    // irq line number for a pin in interrupt mode
    function automatic logic [3:0] irq_num(input logic [2:0] pin,
                                           input logic       r);
        case (pin)
            3'(GFSM_PIN_B1): return r ? 4'h7 : 4'hf;
            3'(GFSM_PIN_B2): return r ? 4'h6 : 4'he;
            3'(GFSM_PIN_C4): return r ? 4'h4 : 4'hc;
            3'(GFSM_PIN_C5): return r ? 4'h3 : 4'hb;
            3'(GFSM_PIN_C6): return 4'ha;
            3'(GFSM_PIN_C7): return r ? 4'h1 : 4'h9;
            default: return 4'h0;
        endcase
    endfunction

    // field extraction from the mode registers
    always_comb begin
        sel[0]   = mode_pb10_reg[`GFSM_LO_SEL];
        sel[1]   = mode_pb10_reg[`GFSM_HI_SEL];
        sel[2]   = mode_pb2_reg[`GFSM_LO_SEL];
        sel[3]   = mode_pc54_reg[`GFSM_LO_SEL];
        sel[4]   = mode_pc54_reg[`GFSM_HI_SEL];
        sel[5]   = mode_pc76_reg[`GFSM_LO_SEL];
        sel[6]   = mode_pc76_reg[`GFSM_HI_SEL];
        route[0] = 1'b0;
        route[1] = mode_pb10_reg[`GFSM_HI_ROUTE];
        route[2] = mode_pb2_reg[`GFSM_LO_ROUTE];
        route[3] = mode_pc54_reg[`GFSM_LO_ROUTE];
        route[4] = mode_pc54_reg[`GFSM_HI_ROUTE];
        route[5] = 1'b0;
        route[6] = mode_pc76_reg[`GFSM_HI_ROUTE];
        gp_data  = {data_c_reg[7:4], data_b_reg[2:0]};
    end

    genvar g;
    generate
        for (g = 0; g < 7; g++) begin : g_pin
            assign drv[g]       = pin_drive(3'(g), sel[g], gp_data[g],
                                            core_out);
            assign irq_mode[g]  = is_irq(3'(g), sel[g]);
            assign irq_event[g] = irq_mode[g] & pin_in[g] & ~pin_in_q_reg[g];
        end
    endgenerate

    // pins to core: unselected functions read as zero
    always_comb begin
        core_in_next = '0;
        for (int i = 0; i < 7; i++) begin
            if (irq_mode[i]) begin
                // route only consulted in interrupt mode
                core_in_next.irq_req[irq_num(3'(i), route[i])] = pin_in[i];
            end
            if (sel[i] == `GFSM_SEL_KEY_RET) begin
                core_in_next.keyscan_return[i] = pin_in[i];
            end
        end
        if (sel[0] == `GFSM_SEL_IRQ) begin
            core_in_next.aux_status_input = pin_in[0];
        end
        if (sel[0] == `GFSM_SEL_ALT_IN) begin
            core_in_next.memcs16 = pin_in[0];
        end
        if (sel[1] == `GFSM_SEL_ALT_IN || sel[3] == `GFSM_SEL_ALT_IN) begin
            core_in_next.iocs16 = (sel[1] == `GFSM_SEL_ALT_IN && pin_in[1])
                               | (sel[3] == `GFSM_SEL_ALT_IN && pin_in[3]);
        end
        if (sel[2] == `GFSM_SEL_ALT_IN || sel[6] == `GFSM_SEL_ALT_IN) begin
            core_in_next.aux_status_input = core_in_next.aux_status_input
                | (sel[2] == `GFSM_SEL_ALT_IN && pin_in[2])
                | (sel[6] == `GFSM_SEL_ALT_IN && pin_in[6]);
        end
        if (sel[5] == `GFSM_SEL_ALT_IN) begin
            core_in_next.serial_receive = pin_in[5];
        end
        // pin C5 code 010 is left unconnected
    end

    // registered pin and core outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out <= 7'h00;
            pin_oe  <= 7'h00;
            core_in <= '0;
        end else begin
            for (int i = 0; i < 7; i++) begin
                pin_out[i] <= drv[i].o;
                pin_oe[i]  <= drv[i].oe;
            end
            core_in <= core_in_next;
        end
    end

    // write channel: address and data taken in either order
    assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
    assign wr_done = s_axi_bvalid & s_axi_bready;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_reg    <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_reg   <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
        end else if (!aw_full_reg) begin
            s_axi_awready <= 1'b1;
        end else if (wr_done) begin
            aw_full_reg   <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_reg    <= 32'h00000000;
            wstrb_reg    <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_reg   <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata;
            wstrb_reg    <= s_axi_wstrb;
        end else if (!w_full_reg) begin
            s_axi_wready <= 1'b1;
        end else if (wr_done) begin
            w_full_reg   <= 1'b0;
        end
    end

    always_comb begin
        {wr_byte, wr_idx} = addr_index(awaddr_reg);
        wr_val  = wdata_reg[7:0];
        // only lane 0 carries register bits; other lanes are ignored
        wr_byte = wr_byte & wr_fire & wstrb_reg[0];
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `GFSM_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (addr_index(awaddr_reg) >> 8 != 9'h0
                             && is_mapped(wr_idx))
                            ? `GFSM_RESP_OKAY : `GFSM_RESP_SLVERR;
        end else if (wr_done) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // mode registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_pb2_reg  <= `GFSM_MODE_RST;
            mode_pb10_reg <= `GFSM_MODE_RST;
            mode_pc76_reg <= `GFSM_MODE_RST;
            mode_pc54_reg <= `GFSM_MODE_RST;
        end else if (wr_byte) begin
            case (wr_idx)
                `GFSM_IDX_PB_MODE_2:
                    mode_pb2_reg  <= wr_val & `GFSM_WMASK_PB_MODE_2;
                `GFSM_IDX_PB_MODE_10:
                    mode_pb10_reg <= wr_val & `GFSM_WMASK_RSV3;
                `GFSM_IDX_PC_MODE_76:
                    mode_pc76_reg <= wr_val & `GFSM_WMASK_RSV3;
                `GFSM_IDX_PC_MODE_54:
                    mode_pc54_reg <= wr_val & `GFSM_WMASK_FULL;
                default: ;
            endcase
        end
    end

    // data registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_b_reg <= `GFSM_DATA_RST;
            data_c_reg <= `GFSM_DATA_RST;
        end else if (wr_byte && wr_idx == `GFSM_IDX_PB_DATA) begin
            data_b_reg <= wr_val;
        end else if (wr_byte && wr_idx == `GFSM_IDX_PC_DATA) begin
            data_c_reg <= wr_val;
        end
    end

    // interrupt status: edge set wins over a write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            int_stat_reg <= 7'h00;
            int_mask_reg <= `GFSM_MASK_RST;
            pin_in_q_reg <= 7'h00;
            irq          <= 1'b0;
        end else begin
            pin_in_q_reg <= pin_in;
            if (wr_byte && wr_idx == `GFSM_IDX_INT_STAT) begin
                int_stat_reg <= (int_stat_reg & ~wr_val[6:0]) | irq_event;
            end else begin
                int_stat_reg <= int_stat_reg | irq_event;
            end
            if (wr_byte && wr_idx == `GFSM_IDX_INT_MASK) begin
                int_mask_reg <= wr_val[6:0];
            end
            irq <= |(int_stat_reg & int_mask_reg);
        end
    end

    // read value; general input pins show their live level
    always_comb begin
        logic [8:0] ai;
        ai     = addr_index(s_axi_araddr);
        rd_ok  = ai[8] & is_mapped(ai[7:0]);
        rd_val = 8'h00;
        case (ai[7:0])
            `GFSM_IDX_PB_MODE_2:  rd_val = mode_pb2_reg;
            `GFSM_IDX_PB_MODE_10: rd_val = mode_pb10_reg;
            `GFSM_IDX_PC_MODE_76: rd_val = mode_pc76_reg;
            `GFSM_IDX_PC_MODE_54: rd_val = mode_pc54_reg;
            `GFSM_IDX_PB_DATA: begin
                rd_val = data_b_reg;
                for (int i = 0; i < 3; i++) begin
                    if (sel[i] == `GFSM_SEL_GP_IN) begin
                        rd_val[i] = pin_in[i];
                    end
                end
            end
            `GFSM_IDX_PC_DATA: begin
                rd_val = data_c_reg;
                for (int i = 3; i < 7; i++) begin
                    if (sel[i] == `GFSM_SEL_GP_IN) begin
                        rd_val[i + 1] = pin_in[i];
                    end
                end
            end
            `GFSM_IDX_INT_STAT: rd_val = {1'b0, int_stat_reg};
            `GFSM_IDX_INT_MASK: rd_val = {1'b0, int_mask_reg};
            default: rd_val = 8'h00;
        endcase
        if (!rd_ok) begin
            rd_val = 8'h00;
        end
    end

    // read channel: one read in flight, answer one cycle after address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `GFSM_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_val};
            s_axi_rresp   <= rd_ok ? `GFSM_RESP_OKAY : `GFSM_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end
endmodule // gfsm_mux

// ===== sim/gfsm_mux_sva.sv
/* port assertions for the pin function select mux
   assumes one clock domain, bound onto gfsm_mux below */
`timescale 1ns/10ps
module gfsm_mux_sva (
    input wire logic                aclk,
    input wire logic                aresetn,
    input wire logic                s_axi_arvalid,
    input wire logic                s_axi_arready,
    input wire logic                s_axi_rvalid,
    input wire logic [31:0]         s_axi_rdata,
    input wire logic                s_axi_bvalid,
    input wire logic                s_axi_bready,
    input wire logic [6:0]          pin_in,
    input wire logic [6:0]          pin_oe,
    input wire gfsm_pkg::gfsm_core_in_t core_in
);
    import gfsm_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic [15:0] r = core_in.irq_req;
    sequence s_ar; s_axi_arvalid && s_axi_arready; endsequence
    sequence s_b_new; $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
    endsequence
    property p_rst; $rose(aresetn) |-> pin_oe == 7'h00; endproperty
    property p_rd_ans; s_ar |=> s_axi_rvalid; endproperty
    property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0;
    endproperty
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid;
    endproperty
    // these lines never have a source pin in this block
    property p_no_irq; (r & 16'h2125) == 16'h0; endproperty
    property p_b1_src; (r[15] || r[7]) |-> $past(pin_in[1]); endproperty
    property p_pair; !(r[15] && r[7]) && !(r[9] && r[1]) &&
        !(r[11] && r[3]) && !(r[12] && r[4]) && !(r[14] && r[6]);
    endproperty
    // pins only change direction after a mode write lands
    property p_oe_wr; $changed(pin_oe) |-> s_b_new; endproperty
    a_rst: assert property (p_rst) else $error("oe after reset");
    a_rd_ans: assert property (p_rd_ans) else $error("no read");
    a_rd_hi: assert property (p_rd_hi) else $error("rdata hi");
    a_b_hold: assert property (p_b_hold) else $error("bvalid");
    a_no_irq: assert property (p_no_irq) else $error("bad irq");
    a_b1_src: assert property (p_b1_src) else $error("irq15");
    a_pair: assert property (p_pair) else $error("two routes");
    a_oe_wr: assert property (p_oe_wr) else $error("oe moved");
endmodule // gfsm_mux_sva
bind gfsm_mux gfsm_mux_sva i_gfsm_mux_sva (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .pin_in, .pin_oe, .core_in);

// ===== sim/gfsm_board_model.sv
/* board side of the multiplexed pins
   assumes ext_level comes from the bench, no pulls on the pins */
`timescale 1ns/10ps
module gfsm_board_model (
    input  wire logic [6:0] pin_out,
    input  wire logic [6:0] pin_oe,
    input  wire logic [6:0] ext_level,
    output logic [6:0]      pin_in
);
    // a driven pin reads back its own level
    always_comb pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule // gfsm_board_model

// ===== sim/gpio_function_select_mux_bench.sv
/* self-checking bench for gfsm_mux
   assumes gfsm_board_model and the checker bound to gfsm_mux */
`timescale 1ns/10ps
`include "gfsm_defines.svh"
module gpio_function_select_mux_bench;
    import gfsm_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, irq;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
    logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
    logic [6:0]  ext = 7'h0, pin_in, pin_out, pin_oe;
    gfsm_core_out_t core_out = '0;
    gfsm_core_in_t  core_in;
    int          num_errors = 0, total_checks = 0;
    // index, value, pin, irq line
    logic [31:0] tab [11] = '{32'h5601020e, 32'h56090206, 32'h5710010f,
        32'h57900107, 32'h58100609, 32'h58900601, 32'h5801050a,
        32'h5910040b, 32'h59900403, 32'h5901030c, 32'h59090304};
    gfsm_mux i_gfsm_mux (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'h1), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pin_out,
        .pin_oe, .core_out, .core_in, .irq);
    gfsm_board_model i_gfsm_board_model (.pin_out, .pin_oe,
        .ext_level(ext), .pin_in);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {2'b00, idx, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        chk(resp, `GFSM_RESP_OKAY);
    endtask
    task automatic rd(input logic [7:0] idx);
        @(posedge aclk);
        s_axi_araddr <= {2'b00, idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic t_regs;
        chk(pin_oe, 7'h0);
        for (int i = 0; i < 3; i++) begin
            rd(8'h57 + i[7:0]);
            chk(rdat, 32'h0);
            wr(8'h57 + i[7:0], 8'hff);
            rd(8'h57 + i[7:0]);
            chk(rdat, (i == 2) ? 32'hff : 32'hf7);
            wr(8'h57 + i[7:0], 8'h00);
        end
        rd(8'h00);
        chk(resp, `GFSM_RESP_SLVERR);
    endtask
    // C4 left masked, so its event must not reach irq
    task automatic t_irq;
        wr(`GFSM_IDX_INT_MASK, 8'h77);
        foreach (tab[i]) begin
            wr(tab[i][31:24], tab[i][23:16]);
            ext <= 7'h1 << tab[i][15:8];
            repeat (4) @(posedge aclk);
            chk(core_in.irq_req, 32'h1 << tab[i][7:0]);
            chk(irq, tab[i][15:8] != 8'd3);
            rd(`GFSM_IDX_INT_STAT);
            chk(rdat, 32'h1 << tab[i][15:8]);
            wr(`GFSM_IDX_INT_STAT, 8'h1 << tab[i][15:8]);
            ext <= 7'h0;
            wr(tab[i][31:24], 8'h00);
            chk(irq, 1'b0);
        end
    endtask
    task automatic t_func;
        wr(8'h59, 8'hc0);
        wr(`GFSM_IDX_PC_DATA, 8'h20);
        ext <= 7'h40;
        repeat (2) @(posedge aclk);
        chk({pin_oe, pin_out[4]}, 8'h21);
        chk(core_in.irq_req, 32'h0);
        rd(`GFSM_IDX_PC_DATA);
        chk(rdat, 32'ha0);
        wr(8'h59, 8'h25);
        repeat (2) @(posedge aclk);
        chk(pin_oe, 7'h0);
        core_out.sysclk <= 1'b1;
        core_out.chip_sel <= 3'b010;
        wr(8'h58, 8'h50);
        wr(8'h57, 8'h56);
        repeat (2) @(posedge aclk);
        chk({pin_oe, pin_out}, 14'h21c1);
        wr(8'h57, 8'h01);
        ext <= 7'h01;
        repeat (3) @(posedge aclk);
        chk(core_in.aux_status_input, 1'b1);
        rd(`GFSM_IDX_INT_STAT);
        chk(rdat, 32'h0);
        // b1 keyscan return, b0 memcs16, c6 serial receive, c4 iocs16
        wr(8'h57, 8'h32);
        wr(8'h58, 8'h02);
        wr(8'h59, 8'h02);
        ext <= 7'h6b;
        repeat (3) @(posedge aclk);
        chk(core_in.keyscan_return, 7'h02);
        chk({core_in.aux_status_input, core_in.iocs16, core_in.memcs16,
             core_in.serial_receive}, 4'h7);
        core_out.keyscan_drive <= 7'h20;
        wr(8'h58, 8'h07);
        repeat (2) @(posedge aclk);
        chk({pin_oe[5], pin_out[5]}, 2'h3);
    endtask
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, total_checks);
        if (num_errors == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial forever #10 aclk = ~aclk;
    // whole run is well under 20 us
    initial begin
        #200000;
        num_errors++;
        close_out;
    end
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        t_regs;
        t_irq;
        t_func;
        close_out;
    end
endmodule // gpio_function_select_mux_bench
